// *** logic/ccs_pkg.sv ***
/*
 * Constants, register map and source encoding for the CPU clock source
 * switcher.
 * Assumes a 50 MHz bus clock and an AXI4-Lite register port.
 */
package ccs_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int HIGH_STAB_US = 65;
  localparam int HIGH_STAB_CYCLES = HIGH_STAB_US * CLK_MHZ;
  localparam int MID_STAB_US = 4;
  localparam int MID_STAB_CYCLES = MID_STAB_US * CLK_MHZ;
  localparam int LOW_STAB_US = 210;
  localparam int LOW_STAB_CYCLES = LOW_STAB_US * CLK_MHZ;
  localparam int MAIN_STAB_US = 102;
  localparam int MAIN_STAB_CYCLES = MAIN_STAB_US * CLK_MHZ;
  // Break-before-make gap of the clock multiplexer
  localparam logic [3:0] MUX_GAP_CYCLES = 4'h2;
  localparam int STAB_CNT_W = 19;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_SUBSYSTEM_SUPPLY_MODE = 8'h00;
  localparam logic [7:0] OFS_OSCILLATOR_MODE_CONFIG = 8'h04;
  localparam logic [7:0] OFS_OSCILLATOR_RUN_CONTROL = 8'h08;
  localparam logic [7:0] OFS_CLOCK_SELECT_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_SUBSYSTEM_SOURCE_SELECT = 8'h10;
  localparam logic [7:0] OFS_STABILIZATION_TIME_SELECT = 8'h14;
  localparam logic [7:0] OFS_STABILIZATION_COUNTER_STATUS = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int INTERVAL_TIMER_CLOCK_SELECT_BIT = 4;
  localparam int LOW_POWER_SUBSYSTEM_BIT = 7;
  localparam int MAIN_GAIN_HIGH_BIT = 0;
  localparam int SUB_OSCILLATOR_SELECT_BIT = 4;
  localparam int SUB_EXTERNAL_INPUT_BIT = 5;
  localparam int MAIN_OSCILLATOR_SELECT_BIT = 6;
  localparam int MAIN_EXTERNAL_INPUT_BIT = 7;
  localparam int HIGH_ONCHIP_STOP_BIT = 0;
  localparam int MID_ONCHIP_ENABLE_BIT = 1;
  localparam int SUB_OSC_STOP_BIT = 6;
  localparam int MAIN_OSC_STOP_BIT = 7;
  localparam int MAIN_ONCHIP_SELECT_BIT = 0;
  localparam int MAIN_ONCHIP_STATUS_BIT = 1;
  localparam int MAIN_SYSTEM_SELECT_BIT = 4;
  localparam int MAIN_SYSTEM_STATUS_BIT = 5;
  localparam int SOURCE_SELECT_BIT = 6;
  localparam int ACTIVE_CLOCK_STATUS_BIT = 7;
  localparam int LOW_SPEED_SELECT_BIT = 0;

  // Writable bits of each register
  localparam logic [7:0] SUPPLY_MODE_MASK = 8'h90;
  localparam logic [7:0] MODE_CONFIG_MASK = 8'hf7;
  localparam logic [7:0] RUN_CONTROL_MASK = 8'hc3;
  localparam logic [7:0] CLOCK_SELECT_MASK = 8'h51;
  localparam logic [7:0] SOURCE_SELECT_MASK = 8'h01;
  localparam logic [7:0] STAB_TIME_MASK = 8'h07;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_SUBSYSTEM_SUPPLY_MODE = 8'h00;
  localparam logic [7:0] RST_OSCILLATOR_MODE_CONFIG = 8'h00;
  localparam logic [7:0] RST_OSCILLATOR_RUN_CONTROL = 8'hc0;
  localparam logic [7:0] RST_CLOCK_SELECT_CONTROL = 8'h00;
  localparam logic [7:0] RST_SUBSYSTEM_SOURCE_SELECT = 8'h00;
  localparam logic [7:0] RST_STABILIZATION_TIME_SELECT = 8'h07;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // CPU/peripheral clock sources, also the bit order of fclk_select
  typedef enum logic [2:0] {
    SRC_HIGH,
    SRC_MID,
    SRC_MAIN,
    SRC_XT,
    SRC_LOW
  } ccs_src_t;

  localparam int NUM_SRC = 5;

endpackage

// *** logic/ccs_switcher.sv ***
/*
 * CPU clock source switcher: oscillator run control, stabilisation
 * counter for the main resonator, break-before-make source multiplexer
 * and the AXI4-Lite register port.
 * Assumes the oscillators themselves are analog cells outside this block,
 * enabled by the run outputs; main_osc_tick is a pin, stop_mode and
 * halt_mode come from the CPU on aclk.
 */
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.

module ccs_switcher (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic main_osc_tick,
  input wire logic stop_mode,
  input wire logic halt_mode,
  output logic high_onchip_run,
  output logic mid_onchip_run,
  output logic low_speed_run,
  output logic main_resonator_enable,
  output logic main_external_enable,
  output logic main_gain_high,
  output logic sub_resonator_enable,
  output logic sub_external_enable,
  output logic [1:0] sub_drive_select,
  output logic interval_timer_low_speed,
  output logic sub_clk_peripheral_enable,
  output logic [4:0] fclk_select,
  output logic main_osc_stable
);

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0] subsystem_supply_mode;
  logic [7:0] oscillator_mode_config;
  logic [7:0] oscillator_run_control;
  logic [7:0] clock_select_control;
  logic [7:0] subsystem_source_select;
  logic [7:0] stabilization_time_select;
  logic [7:0] stabilization_counter_status;
  localparam int STAB_CNT_W_L = ccs_pkg::STAB_CNT_W;
  logic [STAB_CNT_W_L-1:0] stab_count;

  typedef enum logic [1:0] {
    MUX_RUN,
    MUX_DRAIN,
    MUX_ENGAGE
  } ccs_mux_t;

  ccs_mux_t mux_state;
  ccs_pkg::ccs_src_t active_src;
  ccs_pkg::ccs_src_t active_main;
  ccs_pkg::ccs_src_t target_src;
  ccs_pkg::ccs_src_t request_src;
  logic [3:0] gap_count;

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;
  logic tick_meta;
  logic tick_sync;
  logic tick_prev;

  logic onchip_status;
  logic system_status;
  logic clock_status;
  logic [7:0] clock_select_read;

  // ****************************************
  // Helpers
  // ****************************************
  // Address decode shared by the read and write paths
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    unique case (addr)
      ccs_pkg::OFS_SUBSYSTEM_SUPPLY_MODE: reg_index = 4'h0;
      ccs_pkg::OFS_OSCILLATOR_MODE_CONFIG: reg_index = 4'h1;
      ccs_pkg::OFS_OSCILLATOR_RUN_CONTROL: reg_index = 4'h2;
      ccs_pkg::OFS_CLOCK_SELECT_CONTROL: reg_index = 4'h3;
      ccs_pkg::OFS_SUBSYSTEM_SOURCE_SELECT: reg_index = 4'h4;
      ccs_pkg::OFS_STABILIZATION_TIME_SELECT: reg_index = 4'h5;
      ccs_pkg::OFS_STABILIZATION_COUNTER_STATUS: reg_index = 4'h6;
      default: reg_index = 4'hf;
    endcase
  endfunction

  // Exponent of main clock periods behind each flag, bit 7 first
  function automatic int flag_exp(input int bit_pos);
    unique case (bit_pos)
      7: flag_exp = 8;
      6: flag_exp = 9;
      5: flag_exp = 10;
      4: flag_exp = 11;
      3: flag_exp = 13;
      2: flag_exp = 15;
      1: flag_exp = 17;
      default: flag_exp = 18;
    endcase
  endfunction

  // ****************************************
  // Oscillator enables
  // ****************************************
  logic run_high;
  logic run_mid;
  logic run_low;
  logic run_main;
  logic run_sub;
  logic sub_on_cpu;

  always_comb begin
    run_high = !oscillator_run_control[ccs_pkg::HIGH_ONCHIP_STOP_BIT];
    run_mid = oscillator_run_control[ccs_pkg::MID_ONCHIP_ENABLE_BIT];
    run_low = subsystem_source_select[ccs_pkg::LOW_SPEED_SELECT_BIT];
    run_main = oscillator_mode_config[ccs_pkg::MAIN_OSCILLATOR_SELECT_BIT]
      && !oscillator_run_control[ccs_pkg::MAIN_OSC_STOP_BIT];
    run_sub = oscillator_mode_config[ccs_pkg::SUB_OSCILLATOR_SELECT_BIT]
      && !oscillator_run_control[ccs_pkg::SUB_OSC_STOP_BIT];
    sub_on_cpu = (active_src == ccs_pkg::SRC_XT)
      || (active_src == ccs_pkg::SRC_LOW);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_onchip_run <= 1'b0;
      mid_onchip_run <= 1'b0;
      low_speed_run <= 1'b0;
      main_resonator_enable <= 1'b0;
      main_external_enable <= 1'b0;
      main_gain_high <= 1'b0;
      sub_resonator_enable <= 1'b0;
      sub_external_enable <= 1'b0;
      sub_drive_select <= 2'h0;
      interval_timer_low_speed <= 1'b0;
      sub_clk_peripheral_enable <= 1'b0;
    end else begin
      high_onchip_run <= run_high;
      mid_onchip_run <= run_mid;
      low_speed_run <= run_low;
      main_external_enable <= run_main
        && oscillator_mode_config[ccs_pkg::MAIN_EXTERNAL_INPUT_BIT];
      main_resonator_enable <= run_main
        && !oscillator_mode_config[ccs_pkg::MAIN_EXTERNAL_INPUT_BIT];
      main_gain_high <= oscillator_mode_config[ccs_pkg::MAIN_GAIN_HIGH_BIT];
      sub_external_enable <= run_sub
        && oscillator_mode_config[ccs_pkg::SUB_EXTERNAL_INPUT_BIT];
      sub_resonator_enable <= run_sub
        && !oscillator_mode_config[ccs_pkg::SUB_EXTERNAL_INPUT_BIT];
      sub_drive_select <= oscillator_mode_config[2:1];
      interval_timer_low_speed <=
        subsystem_supply_mode[ccs_pkg::INTERVAL_TIMER_CLOCK_SELECT_BIT];
      // With the low-power bit set, other subsystem loads are cut in STOP, and in HALT on a sub source; RTC and timer keep it
      sub_clk_peripheral_enable <= !(
        subsystem_supply_mode[ccs_pkg::LOW_POWER_SUBSYSTEM_BIT]
        && (stop_mode || (halt_mode && sub_on_cpu)));
    end
  end

  // ****************************************
  // Main oscillator stabilisation counter
  // ****************************************
  // Pin is asynchronous; tick_meta feeds only tick_sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_meta <= 1'b0;
      tick_sync <= 1'b0;
      tick_prev <= 1'b0;
    end else begin
      tick_meta <= main_osc_tick;
      tick_sync <= tick_meta;
      tick_prev <= tick_sync;
    end
  end

  logic [7:0] next_flags;
  logic stab_done;

  always_comb begin
    next_flags = 8'h00;
    for (int b = 0; b < 8; b++) begin
      next_flags[b] = stab_count >= (STAB_CNT_W_L'(1) << flag_exp(b));
    end
    // Selected time reached: counting stops there
    stab_done = next_flags[3'h7 - stabilization_time_select[2:0]];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run_main) begin
      stab_count <= '0;
    end else if (tick_sync && !tick_prev && !stab_done) begin
      stab_count <= stab_count + STAB_CNT_W_L'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stabilization_counter_status <= 8'h00;
      main_osc_stable <= 1'b0;
    end else begin
      stabilization_counter_status <= next_flags;
      main_osc_stable <= stab_done && run_main;
    end
  end

  // ****************************************
  // Clock source multiplexer
  // ****************************************
  always_comb begin
    if (clock_select_control[ccs_pkg::SOURCE_SELECT_BIT]) begin
      request_src = run_low ? ccs_pkg::SRC_LOW : ccs_pkg::SRC_XT;
    end else if (clock_select_control[ccs_pkg::MAIN_SYSTEM_SELECT_BIT]) begin
      request_src = ccs_pkg::SRC_MAIN;
    end else if (clock_select_control[ccs_pkg::MAIN_ONCHIP_SELECT_BIT]) begin
      request_src = ccs_pkg::SRC_MID;
    end else begin
      request_src = ccs_pkg::SRC_HIGH;
    end
  end

  // A target stopped at request time is not engaged; stopping the active source is not blocked
  function automatic logic src_running(input ccs_pkg::ccs_src_t s,
                                       input logic [4:0] runs);
    src_running = runs[s];
  endfunction

  logic [4:0] runs_vec;
  assign runs_vec = {run_low, run_sub, run_main, run_mid, run_high};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mux_state <= MUX_RUN;
      active_src <= ccs_pkg::SRC_HIGH;
      active_main <= ccs_pkg::SRC_HIGH;
      target_src <= ccs_pkg::SRC_HIGH;
      gap_count <= 4'h0;
    end else begin
      unique case (mux_state)
        MUX_RUN: begin
          if (request_src != active_src
              && src_running(request_src, runs_vec)) begin
            target_src <= request_src;
            gap_count <= ccs_pkg::MUX_GAP_CYCLES;
            mux_state <= MUX_DRAIN;
          end
        end
        MUX_DRAIN: begin
          if (gap_count == 4'h1) begin
            mux_state <= MUX_ENGAGE;
          end
          gap_count <= gap_count - 4'h1;
        end
        MUX_ENGAGE: begin
          // Status follows at the end of the gap, one cycle before fclk_select shows the new source
          active_src <= target_src;
          if (target_src == ccs_pkg::SRC_HIGH
              || target_src == ccs_pkg::SRC_MID
              || target_src == ccs_pkg::SRC_MAIN) begin
            active_main <= target_src;
          end
          mux_state <= MUX_RUN;
        end
      endcase
    end
  end

  // Break before make: no source selected during the gap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fclk_select <= 5'h00;
    end else if (mux_state == MUX_RUN) begin
      fclk_select <= 5'h01 << active_src;
    end else begin
      fclk_select <= 5'h00;
    end
  end

  always_comb begin
    onchip_status = active_main == ccs_pkg::SRC_MID;
    system_status = active_main == ccs_pkg::SRC_MAIN;
    clock_status = sub_on_cpu;
    clock_select_read = clock_select_control & ccs_pkg::CLOCK_SELECT_MASK;
    clock_select_read[ccs_pkg::MAIN_ONCHIP_STATUS_BIT] = onchip_status;
    clock_select_read[ccs_pkg::MAIN_SYSTEM_STATUS_BIT] = system_status;
    clock_select_read[ccs_pkg::ACTIVE_CLOCK_STATUS_BIT] = clock_status;
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ccs_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (reg_index(aw_addr) == 4'hf) ?
          ccs_pkg::RESP_SLVERR : ccs_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic do_write;
  assign do_write = aw_held && w_held && w_lane0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      subsystem_supply_mode <= ccs_pkg::RST_SUBSYSTEM_SUPPLY_MODE;
      oscillator_mode_config <= ccs_pkg::RST_OSCILLATOR_MODE_CONFIG;
      oscillator_run_control <= ccs_pkg::RST_OSCILLATOR_RUN_CONTROL;
      clock_select_control <= ccs_pkg::RST_CLOCK_SELECT_CONTROL;
      subsystem_source_select <= ccs_pkg::RST_SUBSYSTEM_SOURCE_SELECT;
      stabilization_time_select <= ccs_pkg::RST_STABILIZATION_TIME_SELECT;
    end else if (do_write) begin
      unique case (reg_index(aw_addr))
        4'h0: subsystem_supply_mode <= w_data & ccs_pkg::SUPPLY_MODE_MASK;
        4'h1: oscillator_mode_config <= w_data & ccs_pkg::MODE_CONFIG_MASK;
        4'h2: oscillator_run_control <= w_data & ccs_pkg::RUN_CONTROL_MASK;
        // Status bits are masked off; only select bits store
        4'h3: clock_select_control <= w_data & ccs_pkg::CLOCK_SELECT_MASK;
        // Upper bits stay zero
        4'h4: subsystem_source_select <= w_data & ccs_pkg::SOURCE_SELECT_MASK;
        4'h5: stabilization_time_select <= w_data & ccs_pkg::STAB_TIME_MASK;
        default: ;
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ccs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ccs_pkg::RESP_OKAY;
      unique case (reg_index(s_axi_araddr))
        4'h0: s_axi_rdata <= {24'h000000, subsystem_supply_mode};
        4'h1: s_axi_rdata <= {24'h000000, oscillator_mode_config};
        4'h2: s_axi_rdata <= {24'h000000, oscillator_run_control};
        4'h3: s_axi_rdata <= {24'h000000, clock_select_read};
        4'h4: s_axi_rdata <= {24'h000000, subsystem_source_select};
        4'h5: s_axi_rdata <= {24'h000000, stabilization_time_select};
        4'h6: s_axi_rdata <= {24'h000000, stabilization_counter_status};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= ccs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// *** tb/ccs_osc_model.sv ***
/* Behavioural main resonator or external main clock.
   Assumes run is the design's main enable; the pin idles low while
   stopped, so a dead oscillator never looks like a ticking one. */
module ccs_osc_model #(
  parameter int HALF_NS = 33
) (
  input wire logic run,
  output logic tick
);
  timeunit 1ns;
  timeprecision 1ps;
  // Level lasts over a clock period so the 2FF sync sees each edge
  initial begin
    tick = 1'b0;
    forever begin
      #HALF_NS;
      tick = run ? ~tick : 1'b0;
    end
  end
endmodule

// *** tb/ccs_switcher_monitor.sv ***
/* Port-level checker for the CPU clock source switcher.
   Assumes one clock domain, aresetn synchronous and active low. */
module ccs_switcher_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stop_mode,
  input wire logic halt_mode,
  input wire logic high_onchip_run,
  input wire logic mid_onchip_run,
  input wire logic main_resonator_enable,
  input wire logic main_external_enable,
  input wire logic sub_resonator_enable,
  input wire logic sub_external_enable,
  input wire logic sub_clk_peripheral_enable,
  input wire logic [4:0] fclk_select,
  input wire logic main_osc_stable
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ****************
  // Source multiplexer, stabilisation flag and standby gating
  // ****************
  property p_onehot;
    $onehot0(fclk_select);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two sources");
  property p_bbm;
    $changed(fclk_select) && fclk_select != 5'h00 |-> $past(fclk_select) == 0;
  endproperty
  a_bbm: assert property (p_bbm) else $error("no gap");
  property p_gap;
    fclk_select == 5'h00 |-> ##[1:3] fclk_select != 5'h00;
  endproperty
  a_gap: assert property (p_gap) else $error("gap too long");
  property p_high;
    fclk_select[0] |-> high_onchip_run;
  endproperty
  a_high: assert property (p_high) else $error("high src stopped");
  property p_mid;
    fclk_select[1] |-> mid_onchip_run;
  endproperty
  a_mid: assert property (p_mid) else $error("mid src stopped");
  property p_main;
    fclk_select[2] |-> main_resonator_enable || main_external_enable;
  endproperty
  a_main: assert property (p_main) else $error("main src off");
  property p_sub;
    fclk_select[3] |-> sub_resonator_enable || sub_external_enable;
  endproperty
  a_sub: assert property (p_sub) else $error("sub src off");
  property p_stab;
    !(main_resonator_enable || main_external_enable) |-> ##2 !main_osc_stable;
  endproperty
  a_stab: assert property (p_stab) else $error("stable while off");
  property p_standby;
    aresetn && !stop_mode && !halt_mode |=> sub_clk_peripheral_enable;
  endproperty
  a_standby: assert property (p_standby) else $error("sub gated");
  c_low: cover property (fclk_select == 5'h10);
  c_main: cover property (fclk_select == 5'h04);
  c_xt: cover property (fclk_select == 5'h08);
endmodule

bind ccs_switcher ccs_switcher_monitor i_mon (.aclk, .aresetn, .stop_mode,
  .halt_mode, .high_onchip_run, .mid_onchip_run, .main_resonator_enable,
  .main_external_enable, .sub_resonator_enable, .sub_external_enable,
  .sub_clk_peripheral_enable, .fclk_select, .main_osc_stable);

// *** tb/tb_top.sv ***
/* Self-checking bench for the CPU clock source switcher.
   Assumes an AXI4-Lite master here and a main oscillator model. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, main_osc_tick, stop_mode, halt_mode;
  logic [7:0] s_axi_awaddr, s_axi_araddr, cur;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, high_onchip_run, mid_onchip_run;
  logic low_speed_run, main_resonator_enable, main_external_enable;
  logic main_gain_high, sub_resonator_enable, sub_external_enable;
  logic interval_timer_low_speed, sub_clk_peripheral_enable;
  logic main_osc_stable;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, sub_drive_select, r;
  logic [4:0] fclk_select;
  logic [7:0] rst_v [7];
  int mismatches = 0;
  int checks_done = 0;
  int seed = 60876;
  int n;
  ccs_switcher i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .main_osc_tick,
    .stop_mode, .halt_mode, .high_onchip_run, .mid_onchip_run, .low_speed_run,
    .main_resonator_enable, .main_external_enable, .main_gain_high,
    .sub_resonator_enable, .sub_external_enable, .sub_drive_select,
    .interval_timer_low_speed, .sub_clk_peripheral_enable, .fclk_select,
    .main_osc_stable);
  ccs_osc_model i_osc (.run(main_resonator_enable | main_external_enable),
    .tick(main_osc_tick));
  // ****************
  // Checks and bus cycles
  // ****************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dd,
      input logic [1:0] er = 2'h0);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er = 2'h0);
    rd(a);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic wsrc(input logic [4:0] e);
    n = 0;
    while (fclk_select !== e && n < 20) begin
      @(posedge aclk);
      n++;
    end
    chk({27'h0, fclk_select}, {27'h0, e});
  endtask
  task automatic end_sim;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    mismatches++;
    end_sim();
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, stop_mode, halt_mode} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    rst_v = '{ccs_pkg::RST_SUBSYSTEM_SUPPLY_MODE,
      ccs_pkg::RST_OSCILLATOR_MODE_CONFIG, ccs_pkg::RST_OSCILLATOR_RUN_CONTROL,
      ccs_pkg::RST_CLOCK_SELECT_CONTROL, ccs_pkg::RST_SUBSYSTEM_SOURCE_SELECT,
      ccs_pkg::RST_STABILIZATION_TIME_SELECT, 8'h00};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++)
      rdc(8'(i * 4), {24'h0, rst_v[i]});
    chk({27'h0, fclk_select}, 32'h01);
    cur = 8'h00;
    // Random strobes: a cleared lane 0 must leave the register alone
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      s_axi_wstrb <= v[11:8];
      wr(8'h00, v);
      if (v[8])
        cur = v[7:0] & ccs_pkg::SUPPLY_MODE_MASK;
      rdc(8'h00, {24'h0, cur});
      chkb(interval_timer_low_speed, cur[4]);
    end
    s_axi_wstrb <= 4'hf;
    wr(8'h08, 32'hc2);
    chkb(mid_onchip_run, 1'b1);
    repeat (ccs_pkg::MID_STAB_CYCLES) @(posedge aclk);
    wr(8'h0c, 32'h01);
    wsrc(5'h02);
    rdc(8'h0c, 32'h03);
    wr(8'h08, 32'hc3);
    chkb(high_onchip_run, 1'b0);
    wr(8'h10, 32'h01);
    chkb(low_speed_run, 1'b1);
    repeat (ccs_pkg::LOW_STAB_CYCLES) @(posedge aclk);
    wr(8'h0c, 32'h41);
    wsrc(5'h10);
    rdc(8'h0c, 32'hc3);
    wr(8'h00, 32'h90);
    halt_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    chkb(sub_clk_peripheral_enable, 1'b0);
    halt_mode <= 1'b0;
    repeat (2) @(posedge aclk);
    chkb(sub_clk_peripheral_enable, 1'b1);
    wr(8'h08, 32'hc2);
    chkb(high_onchip_run, 1'b1);
    repeat (ccs_pkg::HIGH_STAB_CYCLES) @(posedge aclk);
    wr(8'h0c, 32'h00);
    wsrc(5'h01);
    rdc(8'h0c, 32'h00);
    wr(8'h04, 32'h47);
    chkb(main_gain_high, 1'b1);
    chk({30'h0, sub_drive_select}, 32'h3);
    wr(8'h14, 32'h02);
    wr(8'h08, 32'h42);
    chkb(main_resonator_enable & ~main_external_enable, 1'b1);
    n = 0;
    do begin
      rd(8'h18);
      n++;
    end while (d !== 32'he0 && n < 3000);
    chk(d, 32'he0);
    chkb(main_osc_stable, 1'b1);
    wr(8'h0c, 32'h10);
    wsrc(5'h04);
    rdc(8'h0c, 32'h30);
    halt_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    chkb(sub_clk_peripheral_enable, 1'b1);
    halt_mode <= 1'b0;
    wr(8'h10, 32'h00);
    chkb(low_speed_run, 1'b0);
    wr(8'h04, 32'h50);
    chkb(main_gain_high, 1'b0);
    wr(8'h08, 32'h02);
    chkb(sub_resonator_enable, 1'b1);
    repeat (500) @(posedge aclk);
    wr(8'h0c, 32'h50);
    wsrc(5'h08);
    rdc(8'h0c, 32'hf0);
    wr(8'h04, 32'hf0);
    chkb(sub_external_enable, 1'b1);
    chkb(main_external_enable & ~main_resonator_enable, 1'b1);
    rdc(8'h1c, 32'h0, ccs_pkg::RESP_SLVERR);
    wr(8'h1c, 32'hff, ccs_pkg::RESP_SLVERR);
    stop_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    chkb(sub_clk_peripheral_enable, 1'b0);
    stop_mode <= 1'b0;
    // Mid-run reset: outputs must come back as after power-up
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({27'h0, fclk_select}, 32'h01);
    chkb(high_onchip_run, 1'b1);
    rdc(8'h08, {24'h0, ccs_pkg::RST_OSCILLATOR_RUN_CONTROL});
    end_sim();
  end
endmodule
